// [hdl/tkd_pkg.sv]
// constants, types and check-byte function shared by the touch-key command decoder
package tkd_pkg;

	// command codes of the run-mode subset
	localparam logic [7:0] CMD_NULL = 8'h00;
	localparam logic [7:0] CMD_CAL_ALL = 8'h03;
	localparam logic [7:0] CMD_FORCE_RST = 8'h04;
	localparam logic [7:0] CMD_GEN_STATUS = 8'h05;
	localparam logic [7:0] CMD_FIRST_TOUCH = 8'h06;
	localparam logic [7:0] CMD_ALL_DETECT = 8'h07;
	localparam logic [7:0] CMD_ALL_ERROR = 8'h0B;
	localparam logic [7:0] CMD_FAIL_DIAG = 8'h0C;

	localparam int NUM_KEYS = 24;
	localparam int RESP_DEPTH = 4;

	// report field positions and fixed values
	localparam int GS_COMMS_ERR_BIT = 6;
	localparam int FT_MULTI_BIT = 7;
	localparam int FT_FAULT_BIT = 6;
	localparam logic [4:0] NO_TOUCH_CODE = 5'h1F;
	localparam logic [7:0] GS_SECOND_BYTE = 8'h00;

	// check byte: polynomial and start value must match the host
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [7:0] CRC_INIT = 8'h00;

	// pairing window for doubled commands, longest time rounds down
	localparam int PAIR_WINDOW_MS = 100;
	localparam int CLK_SYS_HZ = 25_000_000;
	localparam int PAIR_WINDOW_CYC = (CLK_SYS_HZ / 1000) * PAIR_WINDOW_MS;

	// reset values
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [2:0] CNT_RST = 3'h0;

	typedef enum logic [1:0] {
		TKD_IDLE = 2'b00,
		TKD_ARMED = 2'b01,
		TKD_RST_WAIT = 2'b10
	} tkd_state_e;

	typedef logic [7:0] tkd_byte_t;

	// fold one byte into a running check byte, msb first
	function automatic logic [7:0] tkdCrcFold(input logic [7:0] crc, input logic [7:0] data);
		logic [7:0] c;
		c = crc ^ data;
		for (int b = 0; b < 8; b++)
		begin
			c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
		end
		return c;
	endfunction

endpackage

// [hdl/tkd_xfer_if.sv]
// carrier between link-clock port logic and the system-clock decoder core
`timescale 1ns/1ps
interface tkd_xfer_if;
	logic rxTog;
	logic [7:0] rxByte;
	logic txTog;
	logic [7:0] txByte;

	modport link (output rxTog, output rxByte, input txTog, input txByte);
	modport core (input rxTog, input rxByte, output txTog, output txByte);
endinterface

// [hdl/tkd_link_port.sv]
// link-clock side: catches command bytes, presents response bytes
`timescale 1ns/1ps
module tkd_link_port
(
	input wire logic linkClk, // link clock from host
	input wire logic resetn, // async reset, active low
	input wire logic linkCmdStrobe, // one-cycle command byte strobe
	input wire logic [7:0] linkCmdByte, // command byte
	output logic [7:0] linkRespByte, // last response byte clocked out
	output logic linkRespValid, // response byte waiting
	tkd_xfer_if.link xf // toggle handshake to the core
);
	import tkd_pkg::*;

	logic txSync1_r;
	logic txSync2_r;
	logic txSeen_r;

	// byte held stable until the next command strobe
	always_ff @(posedge linkClk or negedge resetn)
	begin
		if (!resetn)
		begin
			xf.rxByte <= BYTE_RST;
			xf.rxTog <= 1'b0;
		end
		else if (linkCmdStrobe)
		begin
			xf.rxByte <= linkCmdByte;
			xf.rxTog <= ~xf.rxTog;
		end
	end

	always_ff @(posedge linkClk or negedge resetn)
	begin
		if (!resetn)
		begin
			txSync1_r <= 1'b0;
			txSync2_r <= 1'b0;
		end
		else
		begin
			txSync1_r <= xf.txTog;
			txSync2_r <= txSync1_r;
		end
	end

	// a later strobe consumes the byte shown
	always_ff @(posedge linkClk or negedge resetn)
	begin
		if (!resetn)
		begin
			txSeen_r <= 1'b0;
			linkRespByte <= BYTE_RST;
			linkRespValid <= 1'b0;
		end
		else if (txSync2_r != txSeen_r)
		begin
			txSeen_r <= txSync2_r;
			linkRespByte <= xf.txByte;
			linkRespValid <= 1'b1;
		end
		else if (linkCmdStrobe)
		begin
			linkRespValid <= 1'b0;
		end
	end

	default clocking @(posedge linkClk); endclocking
	default disable iff (!resetn);

	AST_LINK_NEW_BYTE: assert property (txSync2_r != txSeen_r |=> linkRespValid)
		else $error("response toggle did not raise valid");
endmodule // tkd_link_port

// [hdl/tkd_cmd_decoder.sv]
// run-mode command decoder of the touch-key controller, system-clock core
`timescale 1ns/1ps
module tkd_cmd_decoder
#(
	parameter int PAIR_CYCLES = tkd_pkg::PAIR_WINDOW_CYC // pairing window in clk_sys cycles
)
(
	input wire logic clk_sys, // system clock, 25 MHz
	input wire logic resetn, // async reset, active low
	input wire logic linkClk, // link clock from host
	input wire logic linkCmdStrobe, // command byte strobe, linkClk domain
	input wire logic [7:0] linkCmdByte, // command byte, linkClk domain
	output logic [7:0] linkRespByte, // response byte, linkClk domain
	output logic linkRespValid, // response byte waiting, linkClk domain
	input wire logic [tkd_pkg::NUM_KEYS-1:0] keyDetect, // per-key detect
	input wire logic [tkd_pkg::NUM_KEYS-1:0] keyError, // per-key error
	input wire logic calibrating, // any key in calibration
	input wire logic calFailed5, // a key failed calibration five times
	input wire logic syncFail, // sync failure
	input wire logic [7:0] failureDiag, // drive-line fault bits
	output logic calAllStart, // one-cycle pulse: recalibrate all keys
	output logic softReset // one-cycle pulse: reset the device
);
	import tkd_pkg::*;

	tkd_xfer_if xf ();

	tkd_link_port uLink
	(
		.linkClk(linkClk),
		.resetn(resetn),
		.linkCmdStrobe(linkCmdStrobe),
		.linkCmdByte(linkCmdByte),
		.linkRespByte(linkRespByte),
		.linkRespValid(linkRespValid),
		.xf(xf.link)
	);

	localparam logic [31:0] PAIR_LIM = 32'(PAIR_CYCLES - 1);

	tkd_state_e state_r;
	tkd_byte_t pendCmd_r;
	logic [31:0] pairTimer_r;
	logic rxSync1_r;
	logic rxSync2_r;
	logic rxSeen_r;
	tkd_byte_t respBuf_r [RESP_DEPTH];
	logic [2:0] respCount_r;
	logic [2:0] respIdx_r;
	logic commsErr_r;
	logic calAllStart_r;
	logic softReset_r;
	logic txTog_r;

	logic cmdTake;
	tkd_byte_t cmdByte;
	logic isDouble;
	logic execPair;
	logic doLoad;
	logic doPop;
	logic known;
	logic anyFault;
	logic [4:0] firstKey;
	tkd_byte_t ftByte;
	logic [NUM_KEYS-1:0] field;
	tkd_byte_t loadBuf [RESP_DEPTH];
	logic [2:0] loadCount;

	assign calAllStart = calAllStart_r;
	assign softReset = softReset_r;

	// toggle crossing; the byte itself is stable long before the toggle lands
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			rxSync1_r <= 1'b0;
			rxSync2_r <= 1'b0;
			rxSeen_r <= 1'b0;
		end
		else
		begin
			rxSync1_r <= xf.rxTog;
			rxSync2_r <= rxSync1_r;
			rxSeen_r <= rxSync2_r;
		end
	end

	assign cmdTake = rxSync2_r ^ rxSeen_r;
	assign cmdByte = xf.rxByte;
	assign isDouble = (cmdByte == CMD_CAL_ALL) || (cmdByte == CMD_FORCE_RST);
	assign execPair = cmdTake && (state_r == TKD_ARMED) && (cmdByte == pendCmd_r);
	// while the reset ack drains, only nulls are served
	assign doLoad = cmdTake && (cmdByte != CMD_NULL) && (state_r != TKD_RST_WAIT);
	assign doPop = cmdTake && (cmdByte == CMD_NULL) && (respIdx_r < respCount_r);

	// report contents built from live status in the take cycle
	always_comb
	begin
		anyFault = calibrating | calFailed5 | syncFail | commsErr_r | (|failureDiag);
		firstKey = NO_TOUCH_CODE;
		for (int k = NUM_KEYS - 1; k >= 0; k--)
		begin
			if (keyDetect[k])
			begin
				firstKey = 5'(k);
			end
		end
		ftByte = 8'h00;
		ftByte[FT_MULTI_BIT] = (keyDetect & (keyDetect - 1'b1)) != '0;
		ftByte[FT_FAULT_BIT] = anyFault;
		ftByte[4:0] = firstKey;
		field = (cmdByte == CMD_ALL_DETECT) ? keyDetect : keyError;
		for (int i = 0; i < RESP_DEPTH; i++)
		begin
			loadBuf[i] = 8'h00;
		end
		loadCount = CNT_RST;
		known = 1'b1;
		case (cmdByte)
			CMD_NULL, CMD_CAL_ALL, CMD_FORCE_RST:
			begin
				loadCount = CNT_RST; // first copy answers nothing
			end
			CMD_GEN_STATUS:
			begin
				loadBuf[0][GS_COMMS_ERR_BIT] = commsErr_r;
				loadBuf[1] = GS_SECOND_BYTE;
				loadCount = 3'd2;
			end
			CMD_FIRST_TOUCH:
			begin
				loadBuf[0] = ftByte;
				loadBuf[1] = tkdCrcFold(tkdCrcFold(CRC_INIT, cmdByte), ftByte);
				loadCount = 3'd2;
			end
			CMD_ALL_DETECT, CMD_ALL_ERROR:
			begin
				loadBuf[0] = field[7:0];
				loadBuf[1] = field[15:8];
				loadBuf[2] = field[23:16];
				loadBuf[3] = tkdCrcFold(tkdCrcFold(tkdCrcFold(tkdCrcFold(CRC_INIT, cmdByte),
					field[7:0]), field[15:8]), field[23:16]);
				loadCount = 3'd4;
			end
			CMD_FAIL_DIAG:
			begin
				loadBuf[0] = failureDiag;
				loadBuf[1] = tkdCrcFold(tkdCrcFold(CRC_INIT, cmdByte), failureDiag);
				loadCount = 3'd2;
			end
			default:
			begin
				known = 1'b0;
			end
		endcase
	end

	// pairing of doubled commands
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			state_r <= TKD_IDLE;
			pendCmd_r <= BYTE_RST;
			pairTimer_r <= 32'h0;
		end
		else
		begin
			unique case (state_r)
				TKD_IDLE, TKD_ARMED:
				begin
					if (execPair)
					begin
						state_r <= (cmdByte == CMD_FORCE_RST) ? TKD_RST_WAIT : TKD_IDLE;
					end
					else if (cmdTake && isDouble)
					begin
						state_r <= TKD_ARMED;
						pendCmd_r <= cmdByte;
						pairTimer_r <= 32'h0;
					end
					else if (cmdTake)
					begin
						state_r <= TKD_IDLE;
					end
					else if (state_r == TKD_ARMED && pairTimer_r == PAIR_LIM)
					begin
						state_r <= TKD_IDLE;
					end
					else if (state_r == TKD_ARMED)
					begin
						pairTimer_r <= pairTimer_r + 32'h1;
					end
				end
				TKD_RST_WAIT:
				begin
					if (respIdx_r == respCount_r)
					begin
						state_r <= TKD_IDLE;
					end
				end
			endcase
		end
	end

	// response queue; a fresh command drops the old reply, so a repeat is safe
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			for (int i = 0; i < RESP_DEPTH; i++)
			begin
				respBuf_r[i] <= BYTE_RST;
			end
			respCount_r <= CNT_RST;
			respIdx_r <= CNT_RST;
		end
		else if (doLoad && execPair)
		begin
			respBuf_r[0] <= ~cmdByte;
			respCount_r <= 3'd1;
			respIdx_r <= CNT_RST;
		end
		else if (doLoad)
		begin
			respBuf_r <= loadBuf;
			respCount_r <= loadCount;
			respIdx_r <= CNT_RST;
		end
		else if (doPop)
		begin
			respIdx_r <= respIdx_r + 3'd1;
		end
	end

	// at most one byte crosses per null, none once the reply is used up; the host paces nulls slower than the crossing
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			txTog_r <= 1'b0;
			xf.txByte <= BYTE_RST;
		end
		else if (doPop)
		begin
			txTog_r <= ~txTog_r;
			xf.txByte <= respBuf_r[respIdx_r[1:0]];
		end
	end

	assign xf.txTog = txTog_r;

	// sticky until a general status answer carries it out; a new error wins
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			commsErr_r <= 1'b0;
		end
		else if (doLoad && !known)
		begin
			commsErr_r <= 1'b1;
		end
		else if (doLoad && cmdByte == CMD_GEN_STATUS)
		begin
			commsErr_r <= 1'b0;
		end
	end

	// core takes the pulse and returns to run mode without further commands
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			calAllStart_r <= 1'b0;
			softReset_r <= 1'b0;
		end
		else
		begin
			calAllStart_r <= execPair && (cmdByte == CMD_CAL_ALL);
			softReset_r <= (state_r == TKD_RST_WAIT) && (respIdx_r == respCount_r);
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	AST_CAL_PAIR: assert property (calAllStart_r |-> $past(state_r) == TKD_ARMED &&
		$past(pendCmd_r) == CMD_CAL_ALL && $past(cmdTake))
		else $error("cal-all started without a doubled command");
	AST_CAL_ACK: assert property (calAllStart_r |-> respCount_r == 3'd1 &&
		respBuf_r[0] == 8'hFC && respIdx_r == 3'd0)
		else $error("cal-all ack byte wrong");
	AST_TIMEOUT: assert property (state_r == TKD_ARMED && pairTimer_r == PAIR_LIM && !cmdTake
		|=> state_r == TKD_IDLE && respCount_r == 3'd0 && !calAllStart_r)
		else $error("pairing window did not expire silently");
	AST_RESET_AFTER_ACK: assert property (softReset_r |-> $past(respIdx_r) == 3'd1 &&
		$past(respBuf_r[0]) == 8'hFB && $past(state_r) == TKD_RST_WAIT)
		else $error("reset issued before its ack was sent");
	AST_CANCEL: assert property (state_r == TKD_ARMED && cmdTake && cmdByte != pendCmd_r &&
		!isDouble |=> state_r == TKD_IDLE ##1 !calAllStart_r && !softReset_r)
		else $error("intervening command did not cancel pairing");
	AST_STATUS_ERR: assert property (doLoad && cmdByte == CMD_GEN_STATUS |=>
		respBuf_r[0] == {1'b0, $past(commsErr_r), 6'h00} && respCount_r == 3'd2)
		else $error("unknown command not reported in status");
	AST_ERR_SET: assert property (doLoad && !known |=> commsErr_r)
		else $error("unknown command did not raise the error flag");
	AST_MULTI: assert property (doLoad && cmdByte == CMD_FIRST_TOUCH &&
		$countones(keyDetect) >= 2 |=> respBuf_r[0][7])
		else $error("multiple touches not flagged");
	AST_FAULT: assert property (doLoad && cmdByte == CMD_FIRST_TOUCH &&
		(calibrating || syncFail || calFailed5) |=> respBuf_r[0][6])
		else $error("fault summary bit missing");
	AST_NO_TOUCH: assert property (doLoad && cmdByte == CMD_FIRST_TOUCH && keyDetect == '0
		|=> respBuf_r[0][5:0] == 6'h1F)
		else $error("no-touch code wrong");
	AST_FT_CRC: assert property (doLoad && cmdByte == CMD_FIRST_TOUCH |=> respCount_r == 3'd2
		&& respBuf_r[1] == tkdCrcFold(tkdCrcFold(CRC_INIT, 8'h06), respBuf_r[0]))
		else $error("first-touch check byte wrong");
	AST_ALL_DETECT: assert property (doLoad && cmdByte == CMD_ALL_DETECT |=>
		respCount_r == 3'd4 && {respBuf_r[2], respBuf_r[1], respBuf_r[0]} == $past(keyDetect))
		else $error("detect bitfield wrong");
	AST_ALL_ERR_CRC: assert property (doLoad && cmdByte == CMD_ALL_ERROR |=>
		respBuf_r[3] == tkdCrcFold(tkdCrcFold(tkdCrcFold(tkdCrcFold(CRC_INIT, 8'h0B),
		respBuf_r[0]), respBuf_r[1]), respBuf_r[2]))
		else $error("error bitfield check byte wrong");
	AST_DIAG: assert property (doLoad && cmdByte == CMD_FAIL_DIAG |=> respCount_r == 3'd2 &&
		respBuf_r[0] == $past(failureDiag))
		else $error("diagnosis byte wrong");

	COV_CAL_EXEC: cover property (calAllStart_r);
	COV_RESET_EXEC: cover property (softReset_r);
	COV_TIMEOUT: cover property (state_r == TKD_ARMED ##1 state_r == TKD_IDLE && !cmdTake);
	COV_MULTI_TOUCH: cover property (doLoad && cmdByte == CMD_FIRST_TOUCH && keyDetect[0] &&
		keyDetect[23]);
endmodule // tkd_cmd_decoder

// [tb/tkd_host_model.sv]
// host-side model: link master that sends command bytes and pulls reply bytes
`timescale 1ns/1ps
module tkd_host_model
(
	output logic linkClk, // gated link clock, low between frames
	output logic linkCmdStrobe, // command byte strobe
	output logic [7:0] linkCmdByte, // command byte
	input wire logic [7:0] linkRespByte, // reply byte from device
	input wire logic linkRespValid // reply byte waiting
);
	initial
	begin
		linkClk = 1'b0;
		linkCmdStrobe = 1'b0;
		linkCmdByte = 8'hFF;
	end

	// one frame per byte; a null frame pulls one reply byte
	// frame is long enough for the toggle crossing both ways
	task automatic xfer(input logic [7:0] cmd, output logic [7:0] resp, output logic vld);
		#7;
		linkCmdByte = cmd;
		linkCmdStrobe = 1'b1;
		for (int i = 0; i < 18; i++)
		begin
			#15 linkClk = 1'b1;
			#15 linkClk = 1'b0;
			linkCmdStrobe = 1'b0;
			// released data line must not keep the last value
			linkCmdByte = ~cmd;
		end
		resp = linkRespByte;
		vld = linkRespValid;
	endtask
endmodule // tkd_host_model

// [tb/tkd_cmd_decoder_bench.sv]
// self-checking bench for the touch-key command decoder
`timescale 1ns/1ps
module tkd_cmd_decoder_bench;
	import tkd_pkg::*;
	localparam int PAIR = 200;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic linkClk, linkCmdStrobe, linkRespValid, calAllStart, softReset, rv;
	logic [7:0] linkCmdByte, linkRespByte, rb, e;
	logic [NUM_KEYS-1:0] keyDetect = '0;
	logic [NUM_KEYS-1:0] keyError = '0;
	logic calibrating = 1'b0;
	logic calFailed5 = 1'b0;
	logic syncFail = 1'b0;
	logic [7:0] failureDiag = 8'h00;
	logic [4:0] k;
	int error_cnt = 0;
	int n_tests = 0;
	int calCnt = 0;
	int rstCnt = 0;
	int c0;
	logic [23:0] ftDet [8] = '{24'h0, 24'h000020, 24'h820201, 24'h800000, 24'h0, 24'h0,
		24'h0, 24'h000001};
	logic [3:0] ftFlt [8] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h1, 4'h2, 4'h4, 4'h8};

	always #20 clk_sys = ~clk_sys;

	// pulse counters; scenarios compare against a snapshot
	always @(posedge clk_sys)
	begin
		calCnt <= calCnt + int'(calAllStart);
		rstCnt <= rstCnt + int'(softReset);
	end

	tkd_cmd_decoder #(.PAIR_CYCLES(PAIR)) uut (.clk_sys(clk_sys), .resetn(resetn),
		.linkClk(linkClk), .linkCmdStrobe(linkCmdStrobe), .linkCmdByte(linkCmdByte),
		.linkRespByte(linkRespByte), .linkRespValid(linkRespValid), .keyDetect(keyDetect),
		.keyError(keyError), .calibrating(calibrating), .calFailed5(calFailed5),
		.syncFail(syncFail), .failureDiag(failureDiag), .calAllStart(calAllStart),
		.softReset(softReset));

	tkd_host_model h (.linkClk(linkClk), .linkCmdStrobe(linkCmdStrobe),
		.linkCmdByte(linkCmdByte), .linkRespByte(linkRespByte), .linkRespValid(linkRespValid));

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	function automatic logic [7:0] crcStep(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] x;
		x = c ^ d;
		for (int b = 0; b < 8; b++)
		begin
			x = x[7] ? ((x << 1) ^ CRC_POLY) : (x << 1);
		end
		return x;
	endfunction

	task automatic send(input logic [7:0] cmd);
		h.xfer(cmd, rb, rv);
	endtask

	// query, then one null per reply byte; check byte folds command then data
	task automatic reply(input logic [7:0] cmd, input int n, input logic [31:0] d,
		input bit crc);
		logic [7:0] c;
		c = crcStep(CRC_INIT, cmd);
		send(cmd);
		for (int i = 0; i < n; i++)
		begin
			send(CMD_NULL);
			check(rb, d[8*i+:8]);
			c = crcStep(c, d[8*i+:8]);
		end
		if (crc)
		begin
			send(CMD_NULL);
			check(rb, c);
		end
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial
	begin
		repeat (8) @(negedge clk_sys);
		check({6'h0, calAllStart, softReset}, 8'h00);
		check({7'h0, linkRespValid}, 8'h00);
		resetn = 1'b1;
		repeat (4) @(negedge clk_sys);
		reply(CMD_GEN_STATUS, 2, 32'h0, 1'b0);
		send(8'h2A);
		reply(CMD_FIRST_TOUCH, 1, 32'h5F, 1'b1);
		reply(CMD_GEN_STATUS, 2, 32'h0040, 1'b0);
		reply(CMD_GEN_STATUS, 2, 32'h0, 1'b0);
		$display("test status done");
		for (int i = 0; i < 8; i++)
		begin
			@(negedge clk_sys);
			keyDetect = ftDet[i];
			calibrating = ftFlt[i][0];
			calFailed5 = ftFlt[i][1];
			syncFail = ftFlt[i][2];
			failureDiag = ftFlt[i][3] ? 8'h21 : 8'h00;
			k = 5'h1F;
			for (int j = NUM_KEYS - 1; j >= 0; j--)
				if (keyDetect[j])
					k = 5'(j);
			e = {($countones(keyDetect) > 1), (|ftFlt[i]), 1'b0, k};
			reply(CMD_FIRST_TOUCH, 1, {24'h0, e}, 1'b1);
		end
		$display("test first touch done");
		@(negedge clk_sys);
		keyDetect = 24'hA53C81;
		keyError = 24'h5AC318;
		failureDiag = 8'h5A;
		calibrating = 1'b0;
		syncFail = 1'b0;
		reply(CMD_ALL_DETECT, 3, {8'h0, keyDetect}, 1'b1);
		reply(CMD_ALL_ERROR, 3, {8'h0, keyError}, 1'b1);
		reply(CMD_FAIL_DIAG, 1, {24'h0, failureDiag}, 1'b1);
		// a cut-short reply is repeated by the host and must restart at byte 0
		send(CMD_ALL_DETECT);
		send(CMD_NULL);
		check(rb, keyDetect[7:0]);
		reply(CMD_ALL_DETECT, 3, {8'h0, keyDetect}, 1'b1);
		$display("test bitfields done");
		c0 = calCnt;
		send(CMD_CAL_ALL);
		send(CMD_CAL_ALL);
		check(8'(calCnt - c0), 8'h01);
		send(CMD_NULL);
		check(rb, 8'hFC);
		send(CMD_NULL);
		check({7'h0, rv}, 8'h00);
		reply(CMD_GEN_STATUS, 2, 32'h0, 1'b0);
		// an intervening command must cancel the armed first copy
		send(CMD_CAL_ALL);
		send(CMD_GEN_STATUS);
		send(CMD_CAL_ALL);
		send(CMD_NULL);
		check(8'(calCnt - c0), 8'h01);
		check({7'h0, rv}, 8'h00);
		send(CMD_CAL_ALL);
		repeat (PAIR + 20) @(negedge clk_sys);
		send(CMD_CAL_ALL);
		send(CMD_NULL);
		check(8'(calCnt - c0), 8'h01);
		check({7'h0, rv}, 8'h00);
		$display("test recalibrate done");
		c0 = rstCnt;
		send(CMD_FORCE_RST);
		send(CMD_FORCE_RST);
		check(8'(rstCnt - c0), 8'h00);
		send(CMD_NULL);
		check(rb, 8'hFB);
		repeat (4) @(negedge clk_sys);
		check(8'(rstCnt - c0), 8'h01);
		$display("test forced reset done");
		report_and_stop();
	end

	// whole run is well under 100 us; this cuts a hang short
	initial
	begin
		#300_000;
		error_cnt++;
		$display("[FAIL] t=%0t watchdog expired", $time);
		report_and_stop();
	end
endmodule // tkd_cmd_decoder_bench
